// file: verilog/t1rfc_top.sv
`include "t1rfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module t1rfc_top
    import t1rfc_pkg::*;
#(
    parameter logic       LINE_STD = 1'b0,   // arbitrary value
    parameter logic [3:0] REVISION = 4'h0    // arbitrary value
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // host parallel port
    input  wire t1rfc_pkg::t1rfc_bus_t  bus_i,
    output var  logic [7:0]             rdata_o,
    // receive synchronizer status
    input  wire logic                   frame_loss_i,
    input  wire logic                   carrier_loss_i,
    input  wire logic                   rx_elastic_store_enable_i,
    // receive synchronizer control
    output var  t1rfc_pkg::t1rfc_cfg_t  cfg_o,
    output var  logic                   resync_o,
    output var  t1rfc_pkg::t1rfc_sync_t resync_cause_o
);
    import t1rfc_pkg::*;

    // ----------------------------------------
    // register file
    // ----------------------------------------
    logic [7:0]  rctl1_reg;
    logic [7:0]  rctl1_next;
    logic [7:0]  rctl2_reg;
    logic [7:0]  rctl2_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic [7:0]  ident;

    // identity value, fixed bits 6..4 zero
    assign ident = {LINE_STD, `T1RFC_ID_PAD, REVISION};

    // host writes; identity has no write path, no reset clear of control
    always_comb begin
        rctl1_next = rctl1_reg;
        rctl2_next = rctl2_reg;
        if (bus_i.cs && bus_i.wr) begin
            if (bus_i.addr == `T1RFC_ADDR_RCTL1) begin
                rctl1_next = bus_i.wdata;
            end
            if (bus_i.addr == `T1RFC_ADDR_RCTL2) begin
                rctl2_next = bus_i.wdata;
            end
        end
    end

    // read mux, unmapped reads zero
    always_comb begin
        rdata_next = `T1RFC_ZERO_BYTE;
        if (bus_i.cs && bus_i.rd) begin
            unique case (bus_i.addr)
                `T1RFC_ADDR_IDENT: rdata_next = ident;
                `T1RFC_ADDR_RCTL1: rdata_next = rctl1_reg;
                `T1RFC_ADDR_RCTL2: rdata_next = rctl2_reg;
                default:           rdata_next = `T1RFC_ZERO_BYTE;
            endcase
        end
    end

    // control registers keep contents across reset, as the die does
    always_ff @(posedge clk_i) begin
        rctl1_reg <= rctl1_next;
        rctl2_reg <= rctl2_next;
    end

    // ----------------------------------------
    // decoded configuration
    // ----------------------------------------
    t1rfc_cfg_t cfg_next;
    t1rfc_cfg_t cfg_reg;

    // settings decoded from the control registers
    always_comb begin
        cfg_next.resync_on_frame_loss_only = rctl1_reg[`T1RFC_R1_FRAME_ONLY];
        // select b cleared: criterion from select a
        cfg_next.loss_two_of_five     = rctl1_reg[`T1RFC_R1_LOSS_B] ?
                                        1'b0 : rctl1_reg[`T1RFC_R1_LOSS_A];
        cfg_next.sync_search_coupling = rctl1_reg[`T1RFC_R1_COUPLE];
        cfg_next.auto_resync_allowed  = ~rctl1_reg[`T1RFC_R1_DISABLE];
        cfg_next.substitute_code      = rctl2_reg[`T1RFC_R2_CODE] ?
                                        `T1RFC_ALT_CODE : `T1RFC_IDLE_CODE;
        cfg_next.rx_sync_is_input     = rctl2_reg[`T1RFC_R2_DIR] &
                                        rx_elastic_store_enable_i;
        // rate ignored while the pin is an input
        cfg_next.rx_sync_multiframe   = rctl2_reg[`T1RFC_R2_RATE] &
                                        ~cfg_next.rx_sync_is_input;
        // widening only for frame-rate output pulses
        cfg_next.rx_sync_double_width = rctl2_reg[`T1RFC_R2_DWIDE] &
                                        ~rctl2_reg[`T1RFC_R2_RATE] &
                                        ~rctl2_reg[`T1RFC_R2_DIR];
    end

    // ----------------------------------------
    // resync request generation
    // ----------------------------------------
    logic        manual_rise;
    logic        auto_trig;
    logic        resync_next;
    logic        resync_reg;
    t1rfc_sync_t cause_next;
    t1rfc_sync_t cause_reg;

    // 0->1 of the resync bit
    t1rfc_edge u_edge (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .level_i (rctl1_reg[`T1RFC_R1_RESYNC]),
        .rise_o  (manual_rise)
    );

    // automatic trigger by criteria, gated by enable
    assign auto_trig = cfg_reg.auto_resync_allowed &
                       (frame_loss_i |
                        (~cfg_reg.resync_on_frame_loss_only & carrier_loss_i));

    // request and cause, manual wins over automatic
    always_comb begin
        resync_next = manual_rise | auto_trig;
        cause_next  = T1RFC_SYNC_IDLE;
        if (manual_rise) begin
            cause_next = T1RFC_SYNC_MANUAL;
        end else if (auto_trig) begin
            cause_next = T1RFC_SYNC_AUTO;
        end
    end

    // settings, request and read data registers, cleared by reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_reg    <= '0;
            resync_reg <= 1'b0;
            cause_reg  <= T1RFC_SYNC_IDLE;
            rdata_reg  <= `T1RFC_ZERO_BYTE;
        end else begin
            cfg_reg    <= cfg_next;
            resync_reg <= resync_next;
            cause_reg  <= cause_next;
            rdata_reg  <= rdata_next;
        end
    end

    assign rdata_o        = rdata_reg;
    assign cfg_o          = cfg_reg;
    assign resync_o       = resync_reg;
    assign resync_cause_o = cause_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    // identity reads: variant flag, zero padding, revision
    a_ident_read: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_i.cs && bus_i.rd && bus_i.addr == `T1RFC_ADDR_IDENT) |=>
        rdata_o == {LINE_STD, `T1RFC_ID_PAD, REVISION})
        else $error("identity read wrong");
    a_rev_bits: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_i.cs && bus_i.rd && bus_i.addr == `T1RFC_ADDR_IDENT) |=>
        rdata_o[`T1RFC_ID_REV_MSB:0] == REVISION)
        else $error("revision bits wrong");
    a_ident_zeros: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_i.cs && bus_i.rd && bus_i.addr == `T1RFC_ADDR_IDENT) |=>
        rdata_o[`T1RFC_ID_PAD_MSB:`T1RFC_ID_PAD_LSB] == `T1RFC_ID_PAD)
        else $error("identity reserved bits set");
    // automatic resync criteria and suppression
    a_carrier_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (cfg_reg.resync_on_frame_loss_only && cfg_reg.auto_resync_allowed && carrier_loss_i
         && !frame_loss_i && !manual_rise) |=> !resync_o)
        else $error("carrier loss resynced in frame-only mode");
    a_auto_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (!cfg_reg.auto_resync_allowed && !manual_rise) |=> !resync_o)
        else $error("auto resync while disabled");
    // decoded settings follow the control registers one edge later
    a_loss_sel: assert property (@(posedge clk_i) disable iff (rst_i)
        !rctl1_reg[`T1RFC_R1_LOSS_B] |=>
        cfg_o.loss_two_of_five == $past(rctl1_reg[`T1RFC_R1_LOSS_A]))
        else $error("loss criterion not following select a");
    a_coupling_on: assert property (@(posedge clk_i) disable iff (rst_i)
        rctl1_reg[`T1RFC_R1_COUPLE] |=> cfg_o.sync_search_coupling)
        else $error("cross-coupled search not selected");
    a_coupling_off: assert property (@(posedge clk_i) disable iff (rst_i)
        !rctl1_reg[`T1RFC_R1_COUPLE] |=> !cfg_o.sync_search_coupling)
        else $error("sequential search not selected");
    a_idle_code: assert property (@(posedge clk_i) disable iff (rst_i)
        !rctl2_reg[`T1RFC_R2_CODE] |=> cfg_o.substitute_code == `T1RFC_IDLE_CODE)
        else $error("idle code wrong");
    a_rate_input: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_o.rx_sync_is_input |-> !cfg_o.rx_sync_multiframe && !cfg_o.rx_sync_double_width)
        else $error("rate active with input pin");
    a_dir_store: assert property (@(posedge clk_i) disable iff (rst_i)
        !rx_elastic_store_enable_i |=> !cfg_o.rx_sync_is_input)
        else $error("input direction without elastic store");
    // manual resync: one pulse two edges after the rise
    a_manual_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(rctl1_reg[`T1RFC_R1_RESYNC]) && !$past(rst_i)) |=>
        ##1 resync_o && resync_cause_o == T1RFC_SYNC_MANUAL)
        else $error("manual resync missed");
    a_manual_single: assert property (@(posedge clk_i) disable iff (rst_i)
        (resync_o && resync_cause_o == T1RFC_SYNC_MANUAL) |=> resync_cause_o != T1RFC_SYNC_MANUAL)
        else $error("manual resync longer than one cycle");
    // main scenarios
    c_manual: cover property (@(posedge clk_i) disable iff (rst_i)
        resync_o && resync_cause_o == T1RFC_SYNC_MANUAL);
    c_auto: cover property (@(posedge clk_i) disable iff (rst_i)
        resync_o && resync_cause_o == T1RFC_SYNC_AUTO);
    c_input: cover property (@(posedge clk_i) disable iff (rst_i) cfg_o.rx_sync_is_input);
    c_wide: cover property (@(posedge clk_i) disable iff (rst_i) cfg_o.rx_sync_double_width);
    c_loss_five: cover property (@(posedge clk_i) disable iff (rst_i) cfg_o.loss_two_of_five);
endmodule
`default_nettype wire

// file: verilog/t1rfc_map.svh
`ifndef T1RFC_MAP_SVH
`define T1RFC_MAP_SVH
// register offsets
`define T1RFC_ADDR_IDENT   8'h0f
`define T1RFC_ADDR_RCTL1   8'h2b
`define T1RFC_ADDR_RCTL2   8'h2c
// receive control one bit positions
`define T1RFC_R1_FRAME_ONLY 6
`define T1RFC_R1_LOSS_A    5
`define T1RFC_R1_LOSS_B    4
`define T1RFC_R1_COUPLE    3
`define T1RFC_R1_DISABLE   1
`define T1RFC_R1_RESYNC    0
// receive control two bit positions
`define T1RFC_R2_CODE      7
`define T1RFC_R2_DWIDE     5
`define T1RFC_R2_RATE      4
`define T1RFC_R2_DIR       3
// constants
`define T1RFC_IDLE_CODE    8'h7f
`define T1RFC_ALT_CODE     8'hff
`define T1RFC_ZERO_BYTE    8'h00
// identity layout: padding bits and revision field
`define T1RFC_ID_PAD       3'h0
`define T1RFC_ID_PAD_MSB   6
`define T1RFC_ID_PAD_LSB   4
`define T1RFC_ID_REV_MSB   3
`endif

// file: verilog/t1rfc_pkg.sv
`default_nettype none
package t1rfc_pkg;
    // host parallel port request
    typedef struct packed {
        logic       cs;
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } t1rfc_bus_t;
    // settings handed to the receive synchronizer and sync pin logic
    typedef struct packed {
        logic       resync_on_frame_loss_only;
        logic       loss_two_of_five;
        logic       sync_search_coupling;
        logic       auto_resync_allowed;
        logic [7:0] substitute_code;
        logic       rx_sync_double_width;
        logic       rx_sync_multiframe;
        logic       rx_sync_is_input;
    } t1rfc_cfg_t;
    typedef enum logic [1:0] {
        T1RFC_SYNC_IDLE    = 2'b00,
        T1RFC_SYNC_MANUAL  = 2'b01,
        T1RFC_SYNC_AUTO    = 2'b10
    } t1rfc_sync_t;
endpackage
`default_nettype wire

// file: verilog/t1rfc_edge.sv
`timescale 1ns/1ps
`default_nettype none
// rising edge detector, one-cycle pulse on 0->1 of the level
module t1rfc_edge (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level in, pulse out
    input  wire logic level_i,
    output var  logic rise_o
);
    logic last_reg;
    logic last_next;
    logic rise_reg;
    logic rise_next;

    // next state
    always_comb begin
        last_next = level_i;
        rise_next = level_i & ~last_reg;
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            // follow the level through reset, a bit held high gives no false rise
            last_reg <= last_next;
            rise_reg <= 1'b0;
        end else begin
            last_reg <= last_next;
            rise_reg <= rise_next;
        end
    end

    assign rise_o = rise_reg;
endmodule
`default_nettype wire

// file: tb/t1rfc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side model: synchronizer status levels and elastic store setting
module t1rfc_line_model (
    // clock
    input  wire logic       clk_i,
    // requested levels {frame loss, carrier loss, elastic store}
    input  wire logic [2:0] set_i,
    // status towards the framer control
    output var  logic       frame_loss_o,
    output var  logic       carrier_loss_o,
    output var  logic       es_enable_o
);
    // levels follow one edge late, as a real synchronizer would report them
    always_ff @(posedge clk_i) begin
        frame_loss_o   <= set_i[2];
        carrier_loss_o <= set_i[1];
        es_enable_o    <= set_i[0];
    end
endmodule
`default_nettype wire

// file: tb/t1_receive_framer_control_bench.sv
`include "t1rfc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module t1_receive_framer_control_bench;
    import t1rfc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    t1rfc_bus_t  bus = '0;
    logic [2:0]  line_set = 3'b000;
    logic [7:0]  rdata;
    t1rfc_cfg_t  cfg;
    t1rfc_sync_t cause;
    logic        resync, fl, cl, es;
    int          failures = 0;
    int          samples_checked = 0;
    int          r1, r2, e, i;
    // auto resync table: control one value, {frame loss, carrier loss}, resync expected
    logic [7:0]  a_r1[5] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'h02};
    logic [1:0]  a_in[5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b10};
    logic        a_ex[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    t1rfc_top #(.LINE_STD(1'b1), .REVISION(4'h9)) dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus),
        .rdata_o(rdata), .frame_loss_i(fl), .carrier_loss_i(cl), .rx_elastic_store_enable_i(es),
        .cfg_o(cfg), .resync_o(resync), .resync_cause_o(cause));
    t1rfc_line_model line (.clk_i(clk_i), .set_i(line_set), .frame_loss_o(fl), .carrier_loss_o(cl),
        .es_enable_o(es));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // compare and count
    task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one host cycle, write or read; returns just after the sampling edge
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i) bus <= '{1'b1, wr, !wr, a, d};
        @(posedge clk_i) bus <= '0;
        #1;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // expected decoded settings
    function automatic t1rfc_cfg_t model_cfg(input int a, input int b, input int s);
        t1rfc_cfg_t c;
        c.resync_on_frame_loss_only = a[6];
        c.loss_two_of_five     = a[4] ? 1'b0 : a[5];
        c.sync_search_coupling = a[3];
        c.auto_resync_allowed  = !a[1];
        c.substitute_code      = b[7] ? 8'hff : 8'h7f;
        c.rx_sync_is_input     = b[3] & s[0];
        c.rx_sync_multiframe   = b[4] & !c.rx_sync_is_input;
        c.rx_sync_double_width = b[5] & !b[4] & !b[3];
        return c;
    endfunction
    task automatic give_verdict();
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog, tests
    // ----------------------------------------
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    // about seven times the roughly 700 cycles the tests need
    initial begin
        #500_000;
        failures++;
        give_verdict();
    end
    initial begin
        void'($urandom(5));
        // decoded settings read zero while reset holds; control registers are unknown until cleared
        repeat (19) @(posedge clk_i);
        #1;
        cmp(16'(cfg), 16'h0000);
        @(posedge clk_i) rst_i <= 1'b0;
        cycles(1);
        cmp(16'({rdata, resync, cause}), 16'h0000);
        // clear addresses 0x00 to 0x9f before programming
        for (i = 0; i < 'ha0; i++) access(1'b1, i[7:0], 8'h00);
        cycles(1);
        cmp(16'(cfg), 16'(model_cfg(0, 0, 0)));
        access(1'b1, `T1RFC_ADDR_IDENT, 8'hff);
        access(1'b0, `T1RFC_ADDR_IDENT, 8'h00);
        cmp(16'(rdata), 16'h0089);
        access(1'b1, 8'h30, 8'h5a);
        access(1'b0, 8'h30, 8'h00);
        cmp(16'(rdata), 16'h0000);
        // random settings kept within what software may program
        for (i = 0; i < 24; i++) begin
            e = $urandom_range(1, 0);
            r1 = $urandom_range(255, 0) & 'hfe;
            r2 = $urandom_range(255, 0);
            if (e == 0) r2 = r2 & 'hf7;
            if ((r2 & 'h18) != 0) r2 = r2 & 'hdf;
            @(posedge clk_i) line_set <= {2'b00, e[0]};
            access(1'b1, `T1RFC_ADDR_RCTL1, r1[7:0]);
            access(1'b1, `T1RFC_ADDR_RCTL2, r2[7:0]);
            access(1'b0, `T1RFC_ADDR_RCTL1, 8'h00);
            cmp(16'(rdata), 16'(r1[7:0]));
            access(1'b0, `T1RFC_ADDR_RCTL2, 8'h00);
            cmp(16'(rdata), 16'(r2[7:0]));
            cmp(16'(cfg), 16'(model_cfg(r1, r2, e)));
        end
        // manual resync: one pulse per rise, a rewrite of one gives none
        access(1'b1, `T1RFC_ADDR_RCTL1, 8'h00);
        access(1'b1, `T1RFC_ADDR_RCTL1, 8'h01);
        cycles(1);
        cmp(16'(resync), 16'h0000);
        cycles(1);
        cmp(16'({resync, cause}), 16'h0005);
        cycles(1);
        cmp(16'(resync), 16'h0000);
        access(1'b1, `T1RFC_ADDR_RCTL1, 8'h01);
        repeat (3) begin
            cycles(1);
            cmp(16'(resync), 16'h0000);
        end
        access(1'b1, `T1RFC_ADDR_RCTL1, 8'h00);
        access(1'b1, `T1RFC_ADDR_RCTL1, 8'h01);
        cycles(2);
        cmp(16'({resync, cause}), 16'h0005);
        // reset in mid-run with the resync bit still set: no false rise, controls kept
        @(posedge clk_i) rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) begin
            cycles(1);
            cmp(16'(resync), 16'h0000);
        end
        access(1'b0, `T1RFC_ADDR_RCTL1, 8'h00);
        cmp(16'(rdata), 16'h0001);
        // automatic resync causes and suppression
        for (i = 0; i < 5; i++) begin
            access(1'b1, `T1RFC_ADDR_RCTL1, a_r1[i]);
            @(posedge clk_i) line_set <= {a_in[i], 1'b0};
            cycles(4);
            cmp(16'({resync, cause}), a_ex[i] ? 16'h0006 : 16'h0000);
            @(posedge clk_i) line_set <= 3'b000;
            cycles(3);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
